// ===== hw/mss_cfg.svh
// Sizes, encodings and timing constants of the machine step sequencer
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

`define MSS_LINES       200
`define MSS_LAST_IDX    8'hC7
`define MSS_PC_W        8
`define MSS_DEPTH       8
`define MSS_NIO         32
`define MSS_NERR        96
`define MSS_NCTR        8
`define MSS_CTR_W       10
`define MSS_AN_W        8
`define MSS_SCHED_W     7
`define MSS_SCHED_MAX   7'h63
`define MSS_SCHED_SEL   7'h64
`define MSS_EXT_LSB     9
`define MSS_CLK_NS      50
`define MSS_TENTH_NS    100000000

`endif

// ===== hw/mss_pkg.sv
// Types shared by the machine step sequencer files
`include "mss_cfg.svh"

package mss_pkg;

    // Statement kinds; the first one is the unprogrammed line
    typedef enum logic [4:0]
    {
        MSS_OP_BLANK, MSS_OP_STEP, MSS_OP_SUB, MSS_OP_AWAIT, MSS_OP_SET_OUT, MSS_OP_SET_FLAG,
        MSS_OP_DELAY, MSS_OP_JUMP, MSS_OP_CALL, MSS_OP_RETURN, MSS_OP_SET_CTR, MSS_OP_DEC_CTR,
        MSS_OP_IF_CTR, MSS_OP_IF_OUT, MSS_OP_IF_FLAG, MSS_OP_IF_IN, MSS_OP_WELD, MSS_OP_SET_AOUT,
        MSS_OP_IF_AIN_GT, MSS_OP_IF_AIN_LT, MSS_OP_END, MSS_OP_IF_ERR_ON, MSS_OP_IF_ERR_OFF
    } mss_op_t;

    typedef struct packed
    {
        mss_op_t                 op;
        logic                    lvl;
        logic [6:0]              a;
        logic [`MSS_CTR_W-1:0]   b;
    } mss_stmt_t;

    typedef struct packed
    {
        logic                    we;
        logic [`MSS_PC_W-1:0]    line;
        mss_stmt_t               stmt;
    } mss_prog_wr_t;

    typedef struct packed
    {
        logic                    start;
        logic [`MSS_SCHED_W-1:0] sched;
    } mss_weld_req_t;

    typedef struct packed
    {
        logic                    we;
        logic [2:0]              idx;
        logic [`MSS_CTR_W-1:0]   val;
    } mss_ctr_nv_t;

    typedef enum logic [2:0]
    {
        MSS_ST_IDLE, MSS_ST_RUN, MSS_ST_SEARCH, MSS_ST_DELAY, MSS_ST_WELD, MSS_ST_DONE
    } mss_state_t;

endpackage : mss_pkg

// ===== hw/mss_ret_stack.sv
// Return-point stack for subroutine calls
`timescale 1ns/1ns
`include "mss_cfg.svh"

module mss_ret_stack
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clear_i,
    input  wire logic                   push_i,
    input  wire logic                   pop_i,
    input  wire logic [`MSS_PC_W-1:0]   push_data_i,
    output logic      [`MSS_PC_W-1:0]   top_o,
    output logic                        full_o,
    output logic                        empty_o
);

    logic [`MSS_PC_W-1:0] entry [`MSS_DEPTH];
    logic [3:0]           depth;

    assign full_o  = (depth == 4'(`MSS_DEPTH));
    assign empty_o = (depth == 4'h0);
    assign top_o   = empty_o ? '0 : entry[3'(depth - 4'h1)];

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            depth <= 4'h0;
        else if (clear_i)
            depth <= 4'h0;
        else if (push_i && !full_o)
            depth <= depth + 4'h1;
        else if (pop_i && !empty_o)
            depth <= depth - 4'h1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (push_i && !full_o)
            entry[depth[2:0]] <= push_data_i;
    end

    stack_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (push_i && !full_o && !clear_i) |=> depth == $past(depth) + 4'h1 && top_o == $past(push_data_i))
        else $error("push did not land on top of the stack");

endmodule : mss_ret_stack

// ===== hw/mss_sequencer.sv
// Machine step sequencer: runs stored statements against shared machine I/O
`timescale 1ns/1ns
`include "mss_cfg.svh"

module mss_sequencer
#(
    parameter int unsigned TENTH_CYC = `MSS_TENTH_NS / `MSS_CLK_NS
)
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       primary_start_input_i,
    input  wire logic [`MSS_NIO-1:0]        discrete_input_i,
    input  wire logic [`MSS_NIO-1:0]        discrete_output_state_i,
    input  wire logic [`MSS_NERR-1:0]       error_active_i,
    input  wire logic [`MSS_AN_W-1:0]       analog_input_one_i,
    input  wire logic [`MSS_AN_W-1:0]       analog_input_two_i,
    input  wire logic                       sched_ext_sel_i,
    input  wire logic [`MSS_SCHED_W-1:0]    sched_internal_i,
    input  wire logic                       weld_eos_i,
    input  wire mss_pkg::mss_prog_wr_t      prog_wr_i,
    output logic      [`MSS_NIO-1:0]        discrete_output_o,
    output logic      [`MSS_NIO-1:0]        flags_o,
    output logic      [`MSS_AN_W-1:0]       analog_out_one_o,
    output logic      [`MSS_AN_W-1:0]       analog_out_two_o,
    output mss_pkg::mss_weld_req_t          weld_req_o,
    output mss_pkg::mss_ctr_nv_t            ctr_nv_o,
    output logic                            seq_active_o
);

    // Picks item number n (1-based) of a 32-wide vector
    function automatic logic sel32(input logic [`MSS_NIO-1:0] vec, input logic [6:0] num);
        logic [4:0] idx;
        idx = 5'(num - 7'h01);
        return vec[idx];
    endfunction : sel32

    mss_pkg::mss_state_t            st;
    mss_pkg::mss_stmt_t             prog_mem [`MSS_LINES];
    logic [`MSS_PC_W-1:0]           pc;
    logic [`MSS_PC_W-1:0]           scan;
    logic                           scan_sub;
    logic [6:0]                     scan_num;
    logic [`MSS_CTR_W-1:0]          tenths_left;
    logic [31:0]                    tick_cnt;
    logic [`MSS_CTR_W-1:0]          ctr [`MSS_NCTR];
    logic [`MSS_NIO-1:0]            in_meta;
    logic [`MSS_NIO-1:0]            in_sync;
    logic                           start_meta;
    logic                           start_sync;

    // The discrete inputs and the primary start pin pass two flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            in_meta    <= '0;
            in_sync    <= '0;
            start_meta <= 1'b0;
            start_sync <= 1'b0;
        end
        else
        begin
            in_meta    <= discrete_input_i;
            in_sync    <= in_meta;
            start_meta <= primary_start_input_i;
            start_sync <= start_meta;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prog_mem <= '{default: '0};
        else if (prog_wr_i.we && prog_wr_i.line != 8'h00 && prog_wr_i.line <= 8'(`MSS_LINES))
            prog_mem[prog_wr_i.line - 8'h01] <= prog_wr_i.stmt;
    end

    wire                        pc_valid  = (pc < 8'(`MSS_LINES));
    wire mss_pkg::mss_stmt_t    stmt      = pc_valid ? prog_mem[pc] : '0;
    wire mss_pkg::mss_op_t      op        = stmt.op;
    wire                        running   = (st == mss_pkg::MSS_ST_RUN) && start_sync;
    wire [`MSS_PC_W-1:0]        pc_next   = pc + 8'h01;
    wire                        in_bit    = sel32(in_sync, stmt.a);
    wire                        out_bit   = sel32(discrete_output_state_i, stmt.a);
    wire                        flag_bit  = sel32(flags_o, stmt.a);
    wire [2:0]                  ctr_idx   = 3'(stmt.a - 7'h01);
    wire [`MSS_CTR_W-1:0]       ctr_val   = ctr[ctr_idx];
    wire [`MSS_AN_W-1:0]        ain       = stmt.lvl ? analog_input_two_i : analog_input_one_i;
    wire [6:0]                  jump_num  = (op == mss_pkg::MSS_OP_IF_AIN_GT || op == mss_pkg::MSS_OP_IF_AIN_LT) ?
                                            stmt.a : 7'(stmt.b);
    wire [6:0]                  err_idx   = 7'(stmt.a - 7'h01);
    wire                        err_bit   = (stmt.a != 7'h00) && (stmt.a <= 7'(`MSS_NERR)) && error_active_i[err_idx];
    wire                        err_any   = |error_active_i;
    wire                        tick      = (tick_cnt == TENTH_CYC - 1);
    wire [`MSS_SCHED_W-1:0]     ext_sched = in_sync[`MSS_EXT_LSB +: `MSS_SCHED_W];
    wire mss_pkg::mss_stmt_t    scan_stmt = prog_mem[scan];
    wire mss_pkg::mss_op_t      scan_want = scan_sub ? mss_pkg::MSS_OP_SUB : mss_pkg::MSS_OP_STEP;
    wire                        scan_hit  = (scan_stmt.op == scan_want) && (scan_stmt.b == 10'(scan_num));
    wire [`MSS_PC_W-1:0]        ret_top;
    wire                        stk_full;
    wire                        stk_empty;

    // schedule 100 takes the configured selection
    wire [`MSS_SCHED_W-1:0]     sel_sched = !sched_ext_sel_i ? sched_internal_i :
                                            (ext_sched > `MSS_SCHED_MAX) ? `MSS_SCHED_MAX : ext_sched;
    wire [`MSS_SCHED_W-1:0]     weld_sched = (stmt.a == `MSS_SCHED_SEL) ? sel_sched : stmt.a;

    wire take_jump = (op == mss_pkg::MSS_OP_JUMP) ||
                     (op == mss_pkg::MSS_OP_IF_CTR && ctr_val != '0) ||
                     (op == mss_pkg::MSS_OP_IF_OUT && out_bit == stmt.lvl) ||
                     (op == mss_pkg::MSS_OP_IF_FLAG && flag_bit == stmt.lvl) ||
                     (op == mss_pkg::MSS_OP_IF_IN && in_bit == stmt.lvl) ||
                     (op == mss_pkg::MSS_OP_IF_AIN_GT && ain > stmt.b[`MSS_AN_W-1:0]) ||
                     (op == mss_pkg::MSS_OP_IF_AIN_LT && ain < stmt.b[`MSS_AN_W-1:0]) ||
                     (op == mss_pkg::MSS_OP_IF_ERR_ON && (stmt.a == 7'h00 ? err_any : err_bit)) ||
                     (op == mss_pkg::MSS_OP_IF_ERR_OFF && (stmt.a == 7'h00 ? !err_any : !err_bit));

    wire push    = running && op == mss_pkg::MSS_OP_CALL && !stk_full;
    wire pop     = running && op == mss_pkg::MSS_OP_RETURN && !stk_empty;
    wire ctr_set = running && op == mss_pkg::MSS_OP_SET_CTR && stmt.b != '0;
    wire ctr_dec = running && op == mss_pkg::MSS_OP_DEC_CTR && ctr_val != '0;

    mss_ret_stack u_ret_stack
    (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .clear_i     (!start_sync),
        .push_i      (push),
        .pop_i       (pop),
        .push_data_i (pc_next),
        .top_o       (ret_top),
        .full_o      (stk_full),
        .empty_o     (stk_empty)
    );

    // counters cleared only by power-up reset
    generate
        for (genvar i = 0; i < `MSS_NCTR; i++)
        begin : g_ctr
            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    ctr[i] <= '0;
                else if (ctr_set && ctr_idx == 3'(i))
                    ctr[i] <= stmt.b;
                else if (ctr_dec && ctr_idx == 3'(i))
                    ctr[i] <= ctr[i] - 10'h001;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctr_nv_o <= '0;
        else
            ctr_nv_o <= '{we: ctr_set || ctr_dec, idx: ctr_idx,
                          val: ctr_set ? stmt.b : 10'(ctr_val - 10'h001)};
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_cnt <= '0;
        else if (st != mss_pkg::MSS_ST_DELAY || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st                <= mss_pkg::MSS_ST_IDLE;
            pc                <= '0;
            scan              <= '0;
            scan_sub          <= 1'b0;
            scan_num          <= '0;
            tenths_left       <= '0;
            discrete_output_o <= '0;
            flags_o           <= '0;
            analog_out_one_o  <= '0;
            analog_out_two_o  <= '0;
            weld_req_o        <= '0;
        end
        else if (!start_sync)
        begin
            st                <= mss_pkg::MSS_ST_IDLE;
            pc                <= '0;
            scan              <= '0;
            scan_sub          <= 1'b0;
            scan_num          <= '0;
            tenths_left       <= '0;
            discrete_output_o <= '0;
            flags_o           <= '0;
            analog_out_one_o  <= '0;
            analog_out_two_o  <= '0;
            weld_req_o        <= '0;
        end
        else
        begin
            weld_req_o.start <= 1'b0;
            unique case (st)
                mss_pkg::MSS_ST_IDLE:
                    st <= mss_pkg::MSS_ST_RUN;
                mss_pkg::MSS_ST_RUN:
                begin
                    pc <= pc_next;
                    if (!pc_valid)
                        st <= mss_pkg::MSS_ST_DONE;
                    else
                    begin
                        unique case (op)
                            mss_pkg::MSS_OP_AWAIT:
                                if (in_bit != stmt.lvl)
                                    pc <= pc;
                            mss_pkg::MSS_OP_SET_OUT:
                                discrete_output_o[5'(stmt.a - 7'h01)] <= stmt.lvl;
                            mss_pkg::MSS_OP_SET_FLAG:
                                flags_o[5'(stmt.a - 7'h01)] <= stmt.lvl;
                            mss_pkg::MSS_OP_DELAY:
                            begin
                                tenths_left <= stmt.b;
                                pc          <= pc;
                                st          <= mss_pkg::MSS_ST_DELAY;
                            end
                            mss_pkg::MSS_OP_CALL:
                            begin
                                scan     <= '0;
                                scan_sub <= 1'b1;
                                scan_num <= stmt.a;
                                st       <= stk_full ? mss_pkg::MSS_ST_DONE : mss_pkg::MSS_ST_SEARCH;
                            end
                            mss_pkg::MSS_OP_RETURN:
                                if (!stk_empty)
                                    pc <= ret_top;
                            mss_pkg::MSS_OP_WELD:
                            begin
                                weld_req_o <= '{start: 1'b1, sched: weld_sched};
                                pc         <= pc;
                                st         <= mss_pkg::MSS_ST_WELD;
                            end
                            mss_pkg::MSS_OP_SET_AOUT:
                                if (stmt.a == 7'h02)
                                    analog_out_two_o <= stmt.b[`MSS_AN_W-1:0];
                                else
                                    analog_out_one_o <= stmt.b[`MSS_AN_W-1:0];
                            mss_pkg::MSS_OP_END:
                                st <= mss_pkg::MSS_ST_DONE;
                            default:
                                if (take_jump)
                                begin
                                    scan     <= '0;
                                    scan_sub <= 1'b0;
                                    scan_num <= jump_num;
                                    st       <= mss_pkg::MSS_ST_SEARCH;
                                end
                        endcase
                    end
                end
                mss_pkg::MSS_ST_SEARCH:
                    if (scan_hit)
                    begin
                        pc <= scan;
                        st <= mss_pkg::MSS_ST_RUN;
                    end
                    else if (scan == `MSS_LAST_IDX)
                        st <= mss_pkg::MSS_ST_DONE;
                    else
                        scan <= scan + 8'h01;
                mss_pkg::MSS_ST_DELAY:
                    if (tick)
                    begin
                        if (tenths_left <= 10'h001)
                        begin
                            pc <= pc_next;
                            st <= mss_pkg::MSS_ST_RUN;
                        end
                        else
                            tenths_left <= tenths_left - 10'h001;
                    end
                mss_pkg::MSS_ST_WELD:
                    if (weld_eos_i)
                    begin
                        pc <= pc_next;
                        st <= mss_pkg::MSS_ST_RUN;
                    end
                mss_pkg::MSS_ST_DONE:
                    st <= mss_pkg::MSS_ST_DONE;
            endcase
        end
    end

    assign seq_active_o = (st != mss_pkg::MSS_ST_IDLE) && (st != mss_pkg::MSS_ST_DONE);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence weld_issue;
        running && op == mss_pkg::MSS_OP_WELD ##1 weld_req_o.start;
    endsequence

    start_release_a: assert property (!start_sync |=> st == mss_pkg::MSS_ST_IDLE && pc == 8'h00)
        else $error("sequencer not reset after start release");
    blank_advance_a: assert property (running && op == mss_pkg::MSS_OP_BLANK |=> pc == $past(pc) + 8'h01)
        else $error("blank line did not advance");
    label_noop_a: assert property (running && op == mss_pkg::MSS_OP_STEP
        |=> pc == $past(pc) + 8'h01 && $stable(discrete_output_o))
        else $error("step label had an effect");
    await_hold_a: assert property (running && op == mss_pkg::MSS_OP_AWAIT && in_bit != stmt.lvl
        |=> pc == $past(pc))
        else $error("await passed before input matched");
    set_out_a: assert property (running && op == mss_pkg::MSS_OP_SET_OUT
        |=> discrete_output_o[5'($past(stmt.a) - 7'h01)] == $past(stmt.lvl) && pc == $past(pc) + 8'h01)
        else $error("output not driven");
    delay_hold_a: assert property (st == mss_pkg::MSS_ST_DELAY && start_sync && !tick
        |=> st == mss_pkg::MSS_ST_DELAY)
        else $error("delay ended without a tick");
    search_land_a: assert property (st == mss_pkg::MSS_ST_SEARCH && start_sync && scan_hit
        |=> st == mss_pkg::MSS_ST_RUN && pc == $past(scan))
        else $error("jump did not land on label");
    ctr_zero_a: assert property (running && op == mss_pkg::MSS_OP_IF_CTR && ctr_val == '0
        |=> st == mss_pkg::MSS_ST_RUN && pc == $past(pc) + 8'h01)
        else $error("counter test jumped at zero");
    weld_wait_a: assert property (weld_issue |-> st == mss_pkg::MSS_ST_WELD && !weld_eos_i
        |=> st == mss_pkg::MSS_ST_WELD)
        else $error("weld wait left without end of sequence");
    end_idle_a: assert property (st == mss_pkg::MSS_ST_DONE && start_sync |=> st == mss_pkg::MSS_ST_DONE)
        else $error("sequencer left end state while start held");

endmodule : mss_sequencer

// ===== bench/mss_weld_model.sv
// Weld control model that answers weld starts and mirrors the shared outputs
`timescale 1ns/1ns

module mss_weld_model
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire mss_pkg::mss_weld_req_t weld_req_i,
    input  wire logic [31:0]            drive_i,
    output logic                        weld_eos_o,
    output logic [31:0]                 out_state_o
);
    logic [3:0] wait_cnt;

    assign out_state_o = drive_i;

    // end of sequence pulse after a weld
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_cnt   <= 4'h0;
            weld_eos_o <= 1'b0;
        end
        else
        begin
            weld_eos_o <= (wait_cnt == 4'h1);
            if (weld_req_i.start)
                wait_cnt <= 4'h6;
            else if (wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
        end
    end
endmodule : mss_weld_model

// ===== bench/mss_sequencer_bench.sv
// Self-checking bench for the machine step sequencer
`timescale 1ns/1ns

module mss_sequencer_bench;
    logic                   sys_clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   start = 1'b0;
    logic [31:0]            din = 32'h0;
    logic [95:0]            err = 96'h0;
    logic [7:0]             analog_input_one = 8'h00;
    logic [31:0]            dout, dstate, flags;
    logic [7:0]             aout1, aout2;
    logic                   eos, active;
    mss_pkg::mss_prog_wr_t  wr = '0;
    mss_pkg::mss_weld_req_t wreq;
    mss_pkg::mss_ctr_nv_t   ctr;
    logic [12:0]            ctr_q[$];
    logic [6:0]             sched_seen = 7'h0;
    int                     num_errors = 0;
    int                     check_count = 0;

    initial
    begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    mss_sequencer #(.TENTH_CYC(4)) dut
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .primary_start_input_i(start),
        .discrete_input_i(din), .discrete_output_state_i(dstate), .error_active_i(err),
        .analog_input_one_i(analog_input_one), .analog_input_two_i(8'h00), .sched_ext_sel_i(1'b0),
        .sched_internal_i(7'h00), .weld_eos_i(eos), .prog_wr_i(wr), .discrete_output_o(dout),
        .flags_o(flags), .analog_out_one_o(aout1), .analog_out_two_o(aout2), .weld_req_o(wreq),
        .ctr_nv_o(ctr), .seq_active_o(active)
    );

    mss_weld_model partner
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .weld_req_i(wreq), .drive_i(dout),
        .weld_eos_o(eos), .out_state_o(dstate)
    );

    always @(posedge sys_clk_i)
    begin
        if (ctr.we === 1'b1)
            ctr_q.push_back({ctr.idx, ctr.val});
        if (wreq.start === 1'b1)
            sched_seen <= wreq.sched;
    end

    task print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check_val

    task prog(input logic [7:0] line, input mss_pkg::mss_op_t op, input logic lvl,
              input logic [6:0] a, input logic [9:0] b);
        @(posedge sys_clk_i);
        #5;
        wr = '{1'b1, line, '{op, lvl, a, b}};
    endtask : prog

    task run_to_idle;
        int n;
        n = 0;
        @(posedge sys_clk_i);
        #5;
        wr.we = 1'b0;
        start = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        while (active !== 1'b0 && n < 3000)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        #5;
        check_val("idle", 32'h1, n < 3000);
    endtask : run_to_idle

    task test_program;
        prog(8'd1, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd3, 10'd0);
        prog(8'd2, mss_pkg::MSS_OP_SET_CTR, 1'b0, 7'd2, 10'd999);
        prog(8'd3, mss_pkg::MSS_OP_DEC_CTR, 1'b0, 7'd2, 10'd0);
        prog(8'd4, mss_pkg::MSS_OP_WELD, 1'b0, 7'd5, 10'd0);
        prog(8'd5, mss_pkg::MSS_OP_DELAY, 1'b0, 7'd0, 10'd2);
        prog(8'd6, mss_pkg::MSS_OP_CALL, 1'b0, 7'd7, 10'd0);
        prog(8'd7, mss_pkg::MSS_OP_END, 1'b0, 7'd0, 10'd0);
        prog(8'd8, mss_pkg::MSS_OP_SUB, 1'b0, 7'd0, 10'd7);
        prog(8'd9, mss_pkg::MSS_OP_SET_FLAG, 1'b1, 7'd1, 10'd0);
        prog(8'd10, mss_pkg::MSS_OP_RETURN, 1'b0, 7'd0, 10'd0);
        prog(8'd201, mss_pkg::MSS_OP_END, 1'b0, 7'd0, 10'd0);
        run_to_idle();
        check_val("out", 32'h4, dout);
        check_val("ctr_n", 32'h2, ctr_q.size());
        check_val("ctr_set", {1'b1, 10'd999}, ctr_q[0]);
        check_val("ctr_dec", {1'b1, 10'd998}, ctr_q[1]);
        check_val("sched", 32'h5, sched_seen);
        check_val("flag", 32'h1, flags);
        check_val("ended", 32'h0, active);
    endtask : test_program

    task test_branch;
        @(posedge sys_clk_i);
        #5;
        start = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check_val("released", 32'h0, dout);
        prog(8'd1, mss_pkg::MSS_OP_AWAIT, 1'b1, 7'd4, 10'd0);
        prog(8'd2, mss_pkg::MSS_OP_IF_IN, 1'b1, 7'd4, 10'd3);
        prog(8'd3, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd1, 10'd0);
        prog(8'd4, mss_pkg::MSS_OP_STEP, 1'b0, 7'd0, 10'd3);
        prog(8'd5, mss_pkg::MSS_OP_BLANK, 1'b0, 7'd0, 10'd0);
        prog(8'd6, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd2, 10'd0);
        prog(8'd7, mss_pkg::MSS_OP_END, 1'b0, 7'd0, 10'd0);
        fork
            run_to_idle();
            begin
                repeat (30) @(posedge sys_clk_i);
                #5;
                check_val("await", 32'h1, active);
                din = 32'h8;
            end
        join
        check_val("branch", 32'h2, dout);
    endtask : test_branch

    task test_compare;
        @(posedge sys_clk_i);
        #5;
        start = 1'b0;
        err   = 96'h100;
        analog_input_one  = 8'h78;
        prog(8'd1, mss_pkg::MSS_OP_IF_AIN_GT, 1'b0, 7'd1, 10'd100);
        prog(8'd2, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd1, 10'd0);
        prog(8'd3, mss_pkg::MSS_OP_STEP, 1'b0, 7'd0, 10'd1);
        prog(8'd4, mss_pkg::MSS_OP_IF_ERR_ON, 1'b0, 7'd0, 10'd2);
        prog(8'd5, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd2, 10'd0);
        prog(8'd6, mss_pkg::MSS_OP_STEP, 1'b0, 7'd0, 10'd2);
        prog(8'd7, mss_pkg::MSS_OP_IF_ERR_OFF, 1'b0, 7'd5, 10'd3);
        prog(8'd8, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd3, 10'd0);
        prog(8'd9, mss_pkg::MSS_OP_STEP, 1'b0, 7'd0, 10'd3);
        prog(8'd10, mss_pkg::MSS_OP_IF_CTR, 1'b0, 7'd2, 10'd4);
        prog(8'd11, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd4, 10'd0);
        prog(8'd12, mss_pkg::MSS_OP_STEP, 1'b0, 7'd0, 10'd4);
        prog(8'd13, mss_pkg::MSS_OP_IF_CTR, 1'b0, 7'd3, 10'd1);
        prog(8'd14, mss_pkg::MSS_OP_SET_OUT, 1'b1, 7'd5, 10'd0);
        prog(8'd15, mss_pkg::MSS_OP_END, 1'b0, 7'd0, 10'd0);
        run_to_idle();
        check_val("ain_gt", 32'h0, dout[0]);
        check_val("err_any", 32'h0, dout[1]);
        check_val("err_off", 32'h0, dout[2]);
        check_val("ctr_jump", 32'h0, dout[3]);
        check_val("ctr_zero", 32'h1, dout[4]);
    endtask : test_compare

    initial
    begin
        #(50 * 40000);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        #5;
        rst_n_i = 1'b1;
        test_program();
        test_branch();
        test_compare();
        print_verdict();
    end
endmodule : mss_sequencer_bench
